// File: hw/cgc_regs.vh
// Register offsets, field positions, reset values and timing counts of the clock generation control.
// Assumes a 25 MHz pclk and byte addresses on a 32-bit APB bus.
`ifndef CGC_REGS_VH
`define CGC_REGS_VH

// Register byte offsets.
`define CGC_PLL_CONTROL_OFS 8'h00
`define CGC_CLOCK_OUTPUT_CONTROL_OFS 8'h04
`define CGC_SYS_CLOCK_CONTROL_OFS 8'h08
`define CGC_OSC_CONTROL_OFS 8'h0C
`define CGC_STATUS_OFS 8'h10

// Clock source codes, shared by the system source, clock output and module source fields.
`define CGC_SRC_LOW_SPEED_ONCHIP_OSC 3'h0
`define CGC_SRC_HIGH_SPEED_ONCHIP_OSC 3'h1
`define CGC_SRC_MAIN 3'h2
`define CGC_SRC_SUB 3'h3
`define CGC_SRC_PLL 3'h4
`define CGC_SRC_LAST 3'h4
`define CGC_OSC_INDEPENDENT_WATCHDOG 5
`define CGC_NUM_OSC 6

// pll_control fields.
`define CGC_PLL_DIV_LSB 0
`define CGC_PLL_DIV_MSB 1
`define CGC_PLL_MULT_LSB 8
`define CGC_PLL_MULT_MSB 13
`define CGC_PLL_MULT_MIN 6'h08
`define CGC_PLL_MULT_MAX 6'h0F
`define CGC_PLL_DIV_BY4 2'h2
`define CGC_PLL_DIV_RST 2'h0
`define CGC_PLL_MULT_RST 6'h0B

// clock_output_control fields.
`define CGC_CKO_SEL_LSB 8
`define CGC_CKO_SEL_MSB 11
`define CGC_CKO_EN_BIT 15
`define CGC_CKO_SEL_RST 4'h0

// sys_clock_control fields: source, then four division exponents (ratio is two to the power).
`define CGC_SYS_SRC_LSB 0
`define CGC_SYS_SRC_MSB 2
`define CGC_DIV_FIELD_LSB 4
`define CGC_DIV_FIELD_STEP 4
`define CGC_DIV_MAX 3'h6
`define CGC_SYS_SRC_RST 3'h0
`define CGC_DIV_RST 3'h0

// osc_control fields.
`define CGC_MAIN_DRIVE_BIT 0
`define CGC_SUB_DRIVE_BIT 1
`define CGC_HIZ_EN_BIT 2
`define CGC_REM_SRC_LSB 4
`define CGC_REM_SRC_MSB 6
`define CGC_LPT_SRC_LSB 8
`define CGC_LPT_SRC_MSB 10

// status fields.
`define CGC_STOP_FLAG_BIT 0
`define CGC_FALLBACK_BIT 1
`define CGC_CUR_SRC_LSB 2
`define CGC_CUR_SRC_MSB 4

// Oscillation stop detection: a main clock gap longer than this is a stop.
`define CGC_PCLK_PERIOD_NS 40
`define CGC_STOP_TIME_NS 4000
`define CGC_STOP_CYCLES (`CGC_STOP_TIME_NS / `CGC_PCLK_PERIOD_NS)

`endif

// File: hw/cgc_tick_mux.v
// Glitch-free selector for clock ticks: picks one of five source tick streams.
// Assumes one-cycle tick pulses on pclk and a select that software may change at any time.
`timescale 1ns/100ps
`include "cgc_regs.vh"

module cgc_tick_mux (
	// Clock and reset.
	input wire pclk,
	input wire presetn,
	// Sources and request.
	input wire [4:0] tick_in,
	input wire [2:0] sel_req,
	// Selected stream.
	output reg tick_out,
	output reg [2:0] cur_sel
);

	localparam ST_RUN = 2'b01;
	localparam ST_WAIT = 2'b10;

	reg [1:0] state_reg;

	// A changeover mutes the old stream and resumes only on a whole tick of the new one,
	// so downstream never sees a shortened period fused from two sources.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_RUN;
			cur_sel <= `CGC_SRC_LOW_SPEED_ONCHIP_OSC;
			tick_out <= 1'b0;
		end else begin
			tick_out <= 1'b0;
			case (state_reg)
				ST_RUN: begin
					if (sel_req != cur_sel) begin
						state_reg <= ST_WAIT; // see R20
					end else begin
						tick_out <= tick_in[cur_sel];
					end
				end
				ST_WAIT: begin
					if (tick_in[sel_req]) begin
						cur_sel <= sel_req; // see R20
						state_reg <= ST_RUN;
					end
				end
				default: begin
					state_reg <= ST_RUN;
				end
			endcase
		end
	end

endmodule

// File: hw/cgc_top.v
// Clock generation control: source selection, dividers, PLL control, clock output and stop detection.
// Assumes oscillator outputs arrive as asynchronous levels and all consumers run on pclk with enables.
//
// Contract
// R01: Core clock feeds core, transfer controller, memories.
// R02: Converter uses its clock; others peripheral clock.
// R03: Core, peripheral, converter clocks at most 32 MHz.
// R04: Flash clock 1 to 32 MHz.
// R05: Main stop forces low-speed source, timer high impedance.
// R06: PLL takes main clock, divided 1, 2 or 4.
// R07: Software keeps PLL input 4 to 8 MHz.
// R08: Software keeps PLL output 24 to 32 MHz.
// R09: PLL multiplier four to eight, half steps.
// R10: Multiplier codes 001000 to 001111 only.
// R11: Output pin source field, five legal codes.
// R12: Calendar and watchdog get dedicated clocks.
// R13: Remote receiver, low-power timer use selected oscillator.
// R14: Accuracy monitor sees each oscillator undivided.
// R15: External main clock input at most 20 MHz.
// R16: Drive capacity selectable for main and sub oscillators.
// R17: Fast on-chip 32 MHz, slow on-chip 4 MHz.
// R18: Four independent division ratios.
// R19: Main stop recorded in clearable status flag.
// R20: Source changeover is glitch-free; the remote receiver and low-power timer sources switch without it.
`timescale 1ns/100ps
`include "cgc_regs.vh"

module cgc_top (
	// APB slave.
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Oscillator levels: low-speed, high-speed, main, sub, PLL, watchdog oscillator.
	input wire low_speed_onchip_osc,
	input wire high_speed_onchip_osc,
	input wire main_osc,
	input wire sub_osc,
	input wire pll_osc,
	input wire watchdog_osc,
	// PLL and oscillator control.
	output reg [5:0] pll_multiply_field,
	output reg pll_ref_clock_en,
	output reg main_drive_high,
	output reg sub_drive_high,
	// Clock enables to consumers.
	output reg core_system_clock_en,
	output reg peripheral_bus_clock_en,
	output reg converter_peripheral_clock_en,
	output reg flash_interface_clock_en,
	output reg calendar_sub_clock_en,
	output reg independent_watchdog_clock_en,
	output reg remote_receiver_clock_en,
	output reg low_power_timer_clock_en,
	output reg [5:0] accuracy_monitor_clock_en,
	// Pins and forced states.
	output reg clock_output_pin,
	output reg multifunction_timer_hiz
);

	wire [5:0] osc_raw;
	reg [5:0] sync1_reg;
	reg [5:0] sync2_reg;
	reg [5:0] last_reg;
	wire [5:0] osc_tick;

	reg [1:0] pll_div_reg;
	reg [5:0] pll_mult_reg;
	reg [3:0] cko_sel_reg;
	reg cko_en_reg;
	reg [2:0] sys_src_reg;
	reg [11:0] div_reg;
	reg main_drive_reg;
	reg sub_drive_reg;
	reg hiz_en_reg;
	reg [2:0] rem_src_reg;
	reg [2:0] lpt_src_reg;
	reg stop_flag_reg;
	reg [6:0] stop_cnt_reg;
	reg [1:0] ref_cnt_reg;

	wire [2:0] sys_src_eff;
	wire sys_tick;
	wire [2:0] sys_cur;
	wire cko_tick;
	wire [3:0] div_en;
	wire wr_en;
	wire rd_en;
	wire addr_ok;
	wire [5:0] wr_mult;
	wire [3:0] wr_cko;
	wire [1:0] ref_mask;
	reg [31:0] rd_data;

	assign osc_raw = {watchdog_osc, pll_osc, sub_osc, main_osc, high_speed_onchip_osc, low_speed_onchip_osc};

	// Each oscillator level is brought in through two flip-flops; only the second feeds the edge detector.
	genvar gi;
	generate
		for (gi = 0; gi < `CGC_NUM_OSC; gi = gi + 1) begin : g_sync
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
					last_reg[gi] <= 1'b0;
				end else begin
					sync1_reg[gi] <= osc_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
					last_reg[gi] <= sync2_reg[gi];
				end
			end
			assign osc_tick[gi] = sync2_reg[gi] & ~last_reg[gi];
		end
	endgenerate

	// APB access takes one wait state; the write and the read data land at the edge where pready is seen.
	assign wr_en = psel & penable & pready & pwrite;
	assign rd_en = psel & penable & ~pready & ~pwrite;
	assign addr_ok = (paddr == `CGC_PLL_CONTROL_OFS) || (paddr == `CGC_CLOCK_OUTPUT_CONTROL_OFS) ||
		(paddr == `CGC_SYS_CLOCK_CONTROL_OFS) || (paddr == `CGC_OSC_CONTROL_OFS) || (paddr == `CGC_STATUS_OFS);
	assign wr_mult = pwdata[`CGC_PLL_MULT_MSB:`CGC_PLL_MULT_LSB];
	assign wr_cko = pwdata[`CGC_CKO_SEL_MSB:`CGC_CKO_SEL_LSB];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~addr_ok;
			prdata <= rd_en ? rd_data : 32'h0000_0000;
		end
	end

	always @* begin
		rd_data = 32'h0000_0000;
		case (paddr)
			`CGC_PLL_CONTROL_OFS: begin
				rd_data[`CGC_PLL_DIV_MSB:`CGC_PLL_DIV_LSB] = pll_div_reg;
				rd_data[`CGC_PLL_MULT_MSB:`CGC_PLL_MULT_LSB] = pll_mult_reg;
			end
			`CGC_CLOCK_OUTPUT_CONTROL_OFS: begin
				rd_data[`CGC_CKO_SEL_MSB:`CGC_CKO_SEL_LSB] = cko_sel_reg;
				rd_data[`CGC_CKO_EN_BIT] = cko_en_reg;
			end
			`CGC_SYS_CLOCK_CONTROL_OFS: begin
				rd_data[`CGC_SYS_SRC_MSB:`CGC_SYS_SRC_LSB] = sys_src_reg;
				rd_data[`CGC_DIV_FIELD_LSB + 2:`CGC_DIV_FIELD_LSB] = div_reg[2:0];
				rd_data[`CGC_DIV_FIELD_LSB + 6:`CGC_DIV_FIELD_LSB + 4] = div_reg[5:3];
				rd_data[`CGC_DIV_FIELD_LSB + 10:`CGC_DIV_FIELD_LSB + 8] = div_reg[8:6];
				rd_data[`CGC_DIV_FIELD_LSB + 14:`CGC_DIV_FIELD_LSB + 12] = div_reg[11:9];
			end
			`CGC_OSC_CONTROL_OFS: begin
				rd_data[`CGC_MAIN_DRIVE_BIT] = main_drive_reg;
				rd_data[`CGC_SUB_DRIVE_BIT] = sub_drive_reg;
				rd_data[`CGC_HIZ_EN_BIT] = hiz_en_reg;
				rd_data[`CGC_REM_SRC_MSB:`CGC_REM_SRC_LSB] = rem_src_reg;
				rd_data[`CGC_LPT_SRC_MSB:`CGC_LPT_SRC_LSB] = lpt_src_reg;
			end
			`CGC_STATUS_OFS: begin
				rd_data[`CGC_STOP_FLAG_BIT] = stop_flag_reg;
				rd_data[`CGC_FALLBACK_BIT] = (sys_cur == `CGC_SRC_LOW_SPEED_ONCHIP_OSC) && stop_flag_reg;
				rd_data[`CGC_CUR_SRC_MSB:`CGC_CUR_SRC_LSB] = sys_cur;
			end
			default: begin
				rd_data = 32'h0000_0000;
			end
		endcase
	end

	// Control registers. Writes carrying a prohibited code leave that field unchanged.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_div_reg <= `CGC_PLL_DIV_RST;
			pll_mult_reg <= `CGC_PLL_MULT_RST;
			cko_sel_reg <= `CGC_CKO_SEL_RST;
			cko_en_reg <= 1'b0;
			sys_src_reg <= `CGC_SYS_SRC_RST;
			div_reg <= {4{`CGC_DIV_RST}};
			main_drive_reg <= 1'b0;
			sub_drive_reg <= 1'b0;
			hiz_en_reg <= 1'b0;
			rem_src_reg <= `CGC_SRC_LOW_SPEED_ONCHIP_OSC;
			lpt_src_reg <= `CGC_SRC_LOW_SPEED_ONCHIP_OSC;
		end else if (wr_en) begin
			case (paddr)
				`CGC_PLL_CONTROL_OFS: begin
					if (pwdata[`CGC_PLL_DIV_MSB:`CGC_PLL_DIV_LSB] <= `CGC_PLL_DIV_BY4) begin
						pll_div_reg <= pwdata[`CGC_PLL_DIV_MSB:`CGC_PLL_DIV_LSB]; // see R06
					end
					if (wr_mult >= `CGC_PLL_MULT_MIN && wr_mult <= `CGC_PLL_MULT_MAX) begin
						pll_mult_reg <= wr_mult; // see R09 see R10
					end
				end
				`CGC_CLOCK_OUTPUT_CONTROL_OFS: begin
					if (wr_cko <= {1'b0, `CGC_SRC_LAST}) begin
						cko_sel_reg <= wr_cko; // see R11
					end
					cko_en_reg <= pwdata[`CGC_CKO_EN_BIT];
				end
				`CGC_SYS_CLOCK_CONTROL_OFS: begin
					if (pwdata[`CGC_SYS_SRC_MSB:`CGC_SYS_SRC_LSB] <= `CGC_SRC_LAST) begin
						sys_src_reg <= pwdata[`CGC_SYS_SRC_MSB:`CGC_SYS_SRC_LSB];
					end
					if (pwdata[`CGC_DIV_FIELD_LSB + 2:`CGC_DIV_FIELD_LSB] <= `CGC_DIV_MAX) begin
						div_reg[2:0] <= pwdata[`CGC_DIV_FIELD_LSB + 2:`CGC_DIV_FIELD_LSB]; // see R18
					end
					if (pwdata[`CGC_DIV_FIELD_LSB + 6:`CGC_DIV_FIELD_LSB + 4] <= `CGC_DIV_MAX) begin
						div_reg[5:3] <= pwdata[`CGC_DIV_FIELD_LSB + 6:`CGC_DIV_FIELD_LSB + 4]; // see R18
					end
					if (pwdata[`CGC_DIV_FIELD_LSB + 10:`CGC_DIV_FIELD_LSB + 8] <= `CGC_DIV_MAX) begin
						div_reg[8:6] <= pwdata[`CGC_DIV_FIELD_LSB + 10:`CGC_DIV_FIELD_LSB + 8]; // see R18
					end
					if (pwdata[`CGC_DIV_FIELD_LSB + 14:`CGC_DIV_FIELD_LSB + 12] <= `CGC_DIV_MAX) begin
						div_reg[11:9] <= pwdata[`CGC_DIV_FIELD_LSB + 14:`CGC_DIV_FIELD_LSB + 12]; // see R18
					end
				end
				`CGC_OSC_CONTROL_OFS: begin
					main_drive_reg <= pwdata[`CGC_MAIN_DRIVE_BIT]; // see R16
					sub_drive_reg <= pwdata[`CGC_SUB_DRIVE_BIT]; // see R16
					hiz_en_reg <= pwdata[`CGC_HIZ_EN_BIT];
					if (pwdata[`CGC_REM_SRC_MSB:`CGC_REM_SRC_LSB] <= `CGC_SRC_LAST) begin
						rem_src_reg <= pwdata[`CGC_REM_SRC_MSB:`CGC_REM_SRC_LSB];
					end
					if (pwdata[`CGC_LPT_SRC_MSB:`CGC_LPT_SRC_LSB] <= `CGC_SRC_LAST) begin
						lpt_src_reg <= pwdata[`CGC_LPT_SRC_MSB:`CGC_LPT_SRC_LSB];
					end
				end
				default: begin
					pll_div_reg <= pll_div_reg;
				end
			endcase
		end
	end

	// Stop detection. The gap limit is several periods of the slowest legal main clock.
	// A new stop in the same cycle as a clear keeps the flag set.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_cnt_reg <= 7'h00;
			stop_flag_reg <= 1'b0;
		end else begin
			if (osc_tick[`CGC_SRC_MAIN]) begin
				stop_cnt_reg <= 7'h00;
			end else if (stop_cnt_reg != `CGC_STOP_CYCLES) begin
				stop_cnt_reg <= stop_cnt_reg + 7'h01;
			end
			if (stop_cnt_reg == `CGC_STOP_CYCLES - 1 && !osc_tick[`CGC_SRC_MAIN]) begin
				stop_flag_reg <= 1'b1; // see R19
			end else if (wr_en && paddr == `CGC_STATUS_OFS && pwdata[`CGC_STOP_FLAG_BIT]) begin
				stop_flag_reg <= 1'b0; // see R19
			end
		end
	end

	// While the stop flag stands the system runs from the low-speed oscillator.
	assign sys_src_eff = stop_flag_reg ? `CGC_SRC_LOW_SPEED_ONCHIP_OSC : sys_src_reg; // see R05

	cgc_tick_mux u_sys_mux (
		.pclk(pclk),
		.presetn(presetn),
		.tick_in(osc_tick[4:0]),
		.sel_req(sys_src_eff),
		.tick_out(sys_tick),
		.cur_sel(sys_cur)
	);

	cgc_tick_mux u_cko_mux (
		.pclk(pclk),
		.presetn(presetn),
		.tick_in(osc_tick[4:0]),
		.sel_req(cko_sel_reg[2:0]),
		.tick_out(cko_tick),
		.cur_sel()
	);

	// Four dividers on the system tick: core, peripheral bus, converter, flash interface.
	// Ratios stay within the programmed limits only as software chooses them; nothing here checks rates.
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_div
			reg [6:0] cnt_reg;
			wire [6:0] mask;
			assign mask = (7'h01 << div_reg[gi * 3 +: 3]) - 7'h01;
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt_reg <= 7'h00;
				end else if (sys_tick) begin
					cnt_reg <= (cnt_reg >= mask) ? 7'h00 : cnt_reg + 7'h01; // see R18
				end
			end
			assign div_en[gi] = sys_tick && (cnt_reg >= mask); // see R03 see R04
		end
	endgenerate

	// The PLL reference is the main clock only, divided by 1, 2 or 4.
	assign ref_mask = (pll_div_reg == 2'h0) ? 2'h0 : (pll_div_reg == 2'h1) ? 2'h1 : 2'h3;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_cnt_reg <= 2'h0;
		end else if (osc_tick[`CGC_SRC_MAIN]) begin
			ref_cnt_reg <= (ref_cnt_reg >= ref_mask) ? 2'h0 : ref_cnt_reg + 2'h1; // see R06
		end
	end

	// Registered outputs.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_multiply_field <= `CGC_PLL_MULT_RST;
			pll_ref_clock_en <= 1'b0;
			main_drive_high <= 1'b0;
			sub_drive_high <= 1'b0;
			core_system_clock_en <= 1'b0;
			peripheral_bus_clock_en <= 1'b0;
			converter_peripheral_clock_en <= 1'b0;
			flash_interface_clock_en <= 1'b0;
			calendar_sub_clock_en <= 1'b0;
			independent_watchdog_clock_en <= 1'b0;
			remote_receiver_clock_en <= 1'b0;
			low_power_timer_clock_en <= 1'b0;
			accuracy_monitor_clock_en <= 6'h00;
			clock_output_pin <= 1'b0;
			multifunction_timer_hiz <= 1'b0;
		end else begin
			pll_multiply_field <= pll_mult_reg; // see R09
			pll_ref_clock_en <= osc_tick[`CGC_SRC_MAIN] && (ref_cnt_reg >= ref_mask); // see R06
			main_drive_high <= main_drive_reg; // see R16
			sub_drive_high <= sub_drive_reg; // see R16
			core_system_clock_en <= div_en[0]; // see R01
			peripheral_bus_clock_en <= div_en[1]; // see R02
			converter_peripheral_clock_en <= div_en[2]; // see R02
			flash_interface_clock_en <= div_en[3];
			calendar_sub_clock_en <= osc_tick[`CGC_SRC_SUB]; // see R12
			independent_watchdog_clock_en <= osc_tick[`CGC_OSC_INDEPENDENT_WATCHDOG]; // see R12
			remote_receiver_clock_en <= osc_tick[rem_src_reg]; // see R13
			low_power_timer_clock_en <= osc_tick[lpt_src_reg]; // see R13
			accuracy_monitor_clock_en <= osc_tick; // see R14 see R17
			if (!cko_en_reg) begin
				clock_output_pin <= 1'b0;
			end else if (cko_tick) begin
				clock_output_pin <= ~clock_output_pin; // see R11 see R20
			end
			multifunction_timer_hiz <= stop_flag_reg & hiz_en_reg; // see R05
		end
	end

endmodule

// File: testbench/cgc_chk.sv
// Checker for cgc_top: APB answer timing, enable pulses and the forced timer state.
// Assumes it is bound to cgc_top and sees only its ports.
`timescale 1ns/100ps
module cgc_chk (
	// Bus.
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr,
	// Sources and outputs.
	input logic main_osc,
	input logic watchdog_osc,
	input logic [5:0] pll_multiply_field,
	input logic pll_ref_clock_en,
	input logic core_system_clock_en,
	input logic independent_watchdog_clock_en,
	input logic [5:0] accuracy_monitor_clock_en,
	input logic multifunction_timer_hiz
);
	logic wr_done;
	assign wr_done = pready && pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wait_state_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("pready not one cycle after penable");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("prdata not zero outside answer");
	mult_legal_a: assert property (pll_multiply_field inside {[6'h08:6'h0F]})
		else $error("illegal multiplier code");
	hiz_clear_a: assert property ($fell(multifunction_timer_hiz) |->
		$past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3))
		else $error("hiz dropped without a write");
	wdog_clock_a: assert property ($rose(watchdog_osc) |-> ##[1:6] independent_watchdog_clock_en)
		else $error("watchdog enable missing");
	acc_main_a: assert property ($rose(main_osc) |-> ##[1:6] accuracy_monitor_clock_en[2])
		else $error("monitor enable missing");
	ref_pulse_a: assert property (pll_ref_clock_en |=> !pll_ref_clock_en)
		else $error("reference enable longer than one cycle");
	core_pulse_a: assert property (core_system_clock_en |=> !core_system_clock_en)
		else $error("core enable longer than one cycle");
endmodule
bind cgc_top cgc_chk cgc_chk_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .main_osc(main_osc), .watchdog_osc(watchdog_osc),
	.pll_multiply_field(pll_multiply_field), .pll_ref_clock_en(pll_ref_clock_en),
	.core_system_clock_en(core_system_clock_en), .independent_watchdog_clock_en(independent_watchdog_clock_en),
	.accuracy_monitor_clock_en(accuracy_monitor_clock_en), .multifunction_timer_hiz(multifunction_timer_hiz)
);

// File: testbench/cgc_osc_model.sv
// Oscillator model: six square waves at scaled rates; the main one can be stopped.
// Assumes a free-running pclk; rates are pclk half periods, not real frequencies.
`timescale 1ns/100ps
module cgc_osc_model #(
	// Half periods, byte order {watchdog,pll,sub,main,high_speed_onchip_osc,low_speed_onchip_osc}; main stays slow as an external clock must.
	parameter logic [47:0] HALF = 48'h0B05_0904_0203
) (
	// Clock and control.
	input logic pclk,
	input logic main_run,
	// Oscillator levels.
	output logic [5:0] osc = 6'h00
);
	logic [7:0] cnt_reg [6] = '{default: 8'h00};
	always @(posedge pclk) begin
		for (int i = 0; i < 6; i++) begin
			if (i == 2 && !main_run) begin
				osc[i] <= 1'b0;
				cnt_reg[i] <= 8'h00;
			end else if (cnt_reg[i] + 8'h01 >= HALF[8 * i +: 8]) begin
				osc[i] <= !osc[i];
				cnt_reg[i] <= 8'h00;
			end else begin
				cnt_reg[i] <= cnt_reg[i] + 8'h01;
			end
		end
	end
endmodule

// File: testbench/tb_top.sv
// Bench for cgc_top: APB tasks, oscillator model and counted clock enables.
// Assumes the register map of cgc_regs.vh and a 25 MHz pclk.
`timescale 1ns/100ps
`include "cgc_regs.vh"
module tb_top;
	localparam logic [7:0] a_pll = `CGC_PLL_CONTROL_OFS;
	localparam logic [7:0] a_cko = `CGC_CLOCK_OUTPUT_CONTROL_OFS;
	localparam logic [7:0] a_sys = `CGC_SYS_CLOCK_CONTROL_OFS;
	localparam logic [7:0] a_st = `CGC_STATUS_OFS;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic main_run = 1'b1;
	logic cko_q = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] rd_v;
	logic err_v;
	wire [31:0] prdata;
	wire pready, pslverr, ref_en, md, sd, core, per, conv, flash, cal, wdg, rem, low_power_timer, cko, hiz;
	wire [5:0] osc, mult, acc;
	wire [14:0] mon;
	int n_mismatch = 0;
	int comparisons = 0;
	int cycles = 0;
	int cnt [15];
	int d [15];
	assign mon = {cal, cko ^ cko_q, low_power_timer, rem, ref_en, flash, conv, per, core, acc};
	always #20 pclk = ~pclk;
	cgc_osc_model cgc_osc_model_inst (.pclk(pclk), .main_run(main_run), .osc(osc));
	cgc_top cgc_top_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.low_speed_onchip_osc(osc[0]), .high_speed_onchip_osc(osc[1]), .main_osc(osc[2]), .sub_osc(osc[3]),
		.pll_osc(osc[4]), .watchdog_osc(osc[5]), .pll_multiply_field(mult), .pll_ref_clock_en(ref_en),
		.main_drive_high(md), .sub_drive_high(sd), .core_system_clock_en(core), .peripheral_bus_clock_en(per),
		.converter_peripheral_clock_en(conv), .flash_interface_clock_en(flash), .calendar_sub_clock_en(cal),
		.independent_watchdog_clock_en(wdg), .remote_receiver_clock_en(rem), .low_power_timer_clock_en(low_power_timer),
		.accuracy_monitor_clock_en(acc), .clock_output_pin(cko), .multifunction_timer_hiz(hiz)
	);
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cko_q <= cko;
		cycles <= cycles + 1;
		for (int i = 0; i < 15; i++)
			cnt[i] <= cnt[i] + int'(mon[i]);
		if (cycles == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Counts drift by a tick or two at window edges, so rates are compared with a tolerance.
	task near(input int got, input int exp, input int tol);
		chk(32'(got), (got - exp <= tol && exp - got <= tol) ? 32'(got) : 32'(exp));
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dat;
		@(posedge pclk);
		penable <= 1'b1;
		// No answer time is assumed here; a slave that never answers ends in the cycle ceiling.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd_v, e);
	endtask
	task win;
		int s [15];
		repeat (40) @(posedge pclk);
		s = cnt;
		repeat (400) @(posedge pclk);
		foreach (d[i]) d[i] = cnt[i] - s[i];
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rdc(a_pll, 32'h0000_0B00);
		rdc(a_cko, 32'h0000_0000);
		rdc(a_sys, 32'h0000_0000);
		rdc(`CGC_OSC_CONTROL_OFS, 32'h0000_0000);
		rdc(a_st, 32'h0000_0000);
		apb(1'b1, 8'h14, 32'hFFFF_FFFF);
		chk(err_v, 1'b1);
		rdc(8'h14, 32'h0000_0000);
		chk(err_v, 1'b1);
		$display("test reset and map done");
		for (int c = 8; c < 16; c++) begin
			apb(1'b1, a_pll, 32'(c) << 8);
			repeat (2) @(posedge pclk);
			chk(mult, 6'(c));
		end
		apb(1'b1, a_pll, 32'h0000_3F03);
		rdc(a_pll, 32'h0000_0F00);
		for (int v = 0; v < 3; v++) begin
			apb(1'b1, a_pll, 32'h0000_0B00 | 32'(v));
			win();
			near(d[10] << v, d[2], 2 << v);
		end
		$display("test pll done");
		for (int s = 0; s < 5; s++) begin
			apb(1'b1, a_cko, 32'h0000_8000 | 32'(s) << 8);
			win();
			near(d[13], d[s], 3);
		end
		apb(1'b1, a_cko, 32'h0000_0400);
		repeat (8) @(posedge pclk);
		chk(cko, 1'b0);
		$display("test clock output done");
		apb(1'b1, a_sys, 32'h0003_2101);
		apb(1'b1, a_sys, 32'h0003_2177);
		rdc(a_sys, 32'h0003_2101);
		rdc(a_st, 32'h0000_0004);
		win();
		for (int i = 0; i < 4; i++)
			near(d[6 + i] << i, d[1], 2 << i);
		$display("test dividers done");
		apb(1'b1, `CGC_OSC_CONTROL_OFS, 32'h0000_0137);
		win();
		near(d[11], d[3], 2);
		near(d[12], d[1], 2);
		near(d[14], d[3], 2);
		chk({md, sd}, 2'b11);
		$display("test module sources done");
		apb(1'b1, a_sys, 32'h0000_0002);
		win();
		near(d[6], d[2], 2);
		main_run <= 1'b0;
		repeat (140) @(posedge pclk);
		rdc(a_st, 32'h0000_0003);
		chk(hiz, 1'b1);
		win();
		near(d[6], d[0], 2);
		main_run <= 1'b1;
		repeat (20) @(posedge pclk);
		apb(1'b1, a_st, 32'h0000_0001);
		repeat (30) @(posedge pclk);
		rdc(a_st, 32'h0000_0008);
		chk(hiz, 1'b0);
		$display("test stop fallback done");
		report_and_stop();
	end
endmodule
